// >>> design/sbl_pkg.sv
// shared constants, register map and helpers of the black level and analog control bank
package sbl_pkg;

    // ============================================================
    // register indexes on the serial control bus (8-bit index space)
    localparam logic [7:0] IDX_BLK_OFS_HI = 8'h70; // external black offset, upper three bits
    localparam logic [7:0] IDX_BLK_OFS_LO = 8'h71; // external black offset, lower byte
    localparam logic [7:0] IDX_BLK_SETUP = 8'h72; // black_cancel_setup
    localparam logic [7:0] IDX_ACTL0 = 8'h75; // analog_control_zero
    localparam logic [7:0] IDX_ACTL1 = 8'h76; // analog_control_one
    localparam logic [7:0] IDX_CONV = 8'h77; // converter_setup
    localparam logic [7:0] IDX_ATEST = 8'h78; // analog_test

    // ============================================================
    // reset values
    localparam logic [7:0] RST_BLK_OFS_HI = 8'h07; // -64 upper part
    localparam logic [7:0] RST_BLK_OFS_LO = 8'hC0; // -64 lower part
    localparam logic [7:0] RST_BLK_SETUP = 8'h31; // mode 01, time constant 100, narrow band
    localparam logic [7:0] RST_ACTL0 = 8'h00;
    localparam logic [7:0] RST_ACTL1 = 8'h00;
    localparam logic [7:0] RST_CONV = 8'h5A; // stepped, view cascode, diff ramp, low bits 10
    localparam logic [7:0] RST_ATEST = 8'h00;

    // ============================================================
    // writable bit masks; bits outside read back as zero
    localparam logic [7:0] MSK_BLK_OFS_HI = 8'h07;
    localparam logic [7:0] MSK_BLK_SETUP = 8'h3F;
    localparam logic [7:0] MSK_CONV = 8'h7F;
    localparam logic [7:0] MSK_ATEST = 8'h1F;

    // ============================================================
    // field positions
    localparam int BS_MODE_LO = 0; // cancellation mode, two bits
    localparam int BS_TC_LO = 2; // time constant, three bits
    localparam int BS_NARROW = 5; // narrow deadband select
    localparam int A0_CLAMP = 0;
    localparam int A0_TEST = 1;
    localparam int A0_WREF_LO = 2; // white reference, two bits
    localparam int A0_ANTIBLOOM = 4;
    localparam int A0_DIFF_CLK_PD = 5;
    localparam int A0_MEM_CMP_PD = 6;
    localparam int A0_CCS_PD = 7;
    localparam int A1_STANDBY = 0;
    localparam int A1_RAMP_PD = 1;
    localparam int A1_COL_ADC_PD = 2;
    localparam int A1_ARRAY_REG_PD = 3;
    localparam int A1_AUDIO_REG_PD = 4;
    localparam int A1_TOPREF_PD = 5;
    localparam int A1_RAMP_CM = 6;
    localparam int A1_CMP_BIAS = 7;
    localparam int CV_DOUBLER = 2;
    localparam int CV_DIFF_RAMP = 3;
    localparam int CV_VIEW_CAS = 4;
    localparam int CV_VIEW_TEST = 5;
    localparam int CV_STEPPED = 6;
    localparam int AT_MEM_TEST = 0;
    localparam int AT_TOPREF_LO = 1; // top reference voltage select, two bits
    localparam int AT_PHASE_LO = 3; // integration phasing, two bits

    // ============================================================
    // cancellation modes and loop constants
    localparam logic [1:0] MODE_INTERNAL = 2'b01;
    localparam logic [1:0] MODE_EXTERNAL = 2'b11;
    localparam int BL_FRAC = 8; // fractional bits of the leaky integrator
    localparam int SUM_W = 13; // signed width of pixel plus offset arithmetic
    localparam int DB_WIDE = 4; // deadband half width, codes
    localparam int DB_NARROW = 2;
    localparam logic [9:0] PIX_MAX = 10'h3FF;

    // loop state, gray along acc -> upd -> acc
    typedef enum logic [0:0] {
        SBL_ST_ACC = 1'b0,
        SBL_ST_UPD = 1'b1
    } sbl_state_t;

    // clamp a signed sum into the 10-bit pixel range
    function automatic logic [9:0] sbl_clip(input logic signed [SUM_W-1:0] v);
        logic [9:0] r;
        r = v[9:0];
        if (v < 0) begin
            r = 10'h000;
        end else if (v > $signed({3'b000, PIX_MAX})) begin
            r = PIX_MAX;
        end
        return r;
    endfunction

endpackage

// >>> design/sbl_loop_if.sv
// carrier between the register bank and the black level loop
`timescale 1ns/1ps
interface sbl_loop_if #(parameter int PIX_W = 10);
    logic [PIX_W-1:0] pix; // raw pixel
    logic pix_vld; // pixel strobe
    logic black; // pixel belongs to a black line
    logic [2:0] tc; // time constant
    logic narrow; // narrow deadband
    logic [PIX_W-1:0] avg; // reported black average
    logic avg_vld; // one-cycle pulse with a new average
    logic signed [PIX_W+1:0] est; // tracked black level, integer part
    modport ctrl (output pix, pix_vld, black, tc, narrow, input avg, avg_vld, est);
    modport loop (input pix, pix_vld, black, tc, narrow, output avg, avg_vld, est);
endinterface

// >>> design/sbl_black_loop.sv
// black pixel accumulator, averager and leaky integrator
`timescale 1ns/1ps
module sbl_black_loop import sbl_pkg::*; #(
    parameter int PIX_W = 10,
    parameter int SAMPLES_LOG2 = 4,
    parameter int TARGET = 64
) (
    input wire logic clk_sys,
    input wire logic rstn,
    sbl_loop_if.loop lp
);
    // ============================================================
    // declarations
    localparam int ACC_W = PIX_W + SAMPLES_LOG2;
    localparam int INT_W = PIX_W + 2;
    localparam int IW = INT_W + BL_FRAC;
    logic [ACC_W-1:0] acc_q; // running black sum
    logic [ACC_W-1:0] acc_sum; // sum including current pixel
    logic [SAMPLES_LOG2-1:0] cnt_q; // samples taken
    logic wrap; // last sample of a block
    logic [PIX_W-1:0] avg_q;
    logic avg_vld_q;
    sbl_state_t state_q;
    logic signed [IW-1:0] integ_q; // level estimate, fixed point
    logic signed [INT_W-1:0] err; // average minus estimate
    logic signed [IW-1:0] step; // scaled correction
    logic signed [INT_W-1:0] db; // deadband half width
    logic in_band;

    assign acc_sum = acc_q + ACC_W'(lp.pix);
    assign wrap = lp.pix_vld && lp.black && (cnt_q == {SAMPLES_LOG2{1'b1}});
    assign err = $signed({2'b00, avg_q}) - integ_q[IW-1:BL_FRAC];
    assign step = $signed({err, {BL_FRAC{1'b0}}}) >>> lp.tc;
    assign db = lp.narrow ? INT_W'(DB_NARROW) : INT_W'(DB_WIDE);
    assign in_band = (err <= db) && (err >= -db);
    assign lp.avg = avg_q;
    assign lp.avg_vld = avg_vld_q;
    assign lp.est = integ_q[IW-1:BL_FRAC];

    // ============================================================
    // accumulate black pixels in every mode; a power of two keeps the divide a shift
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            acc_q <= '0;
            cnt_q <= '0;
        end else if (wrap) begin
            acc_q <= '0;
            cnt_q <= '0;
        end else if (lp.pix_vld && lp.black) begin
            acc_q <= acc_sum;
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // average and report, one pulse per block
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            avg_q <= '0;
            avg_vld_q <= 1'b0;
        end else begin
            avg_vld_q <= wrap;
            if (wrap) begin
                avg_q <= acc_sum[ACC_W-1:SAMPLES_LOG2];
            end
        end
    end

    // sequencer: one update cycle after each new average
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= SBL_ST_ACC;
        end else begin
            case (state_q)
                SBL_ST_ACC: state_q <= wrap ? SBL_ST_UPD : SBL_ST_ACC;
                SBL_ST_UPD: state_q <= SBL_ST_ACC;
                default: state_q <= SBL_ST_ACC;
            endcase
        end
    end

    // leaky integrator; larger time constant means smaller steps
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            integ_q <= IW'(TARGET) <<< BL_FRAC;
        end else if (state_q == SBL_ST_UPD && !in_band) begin
            integ_q <= integ_q + step;
        end
    end

    // ============================================================
    // checks
    a_deadband_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_q == SBL_ST_UPD && in_band |=> $stable(integ_q) ##1 $stable(integ_q))
        else $error("integrator moved inside deadband");
    a_tc_zero_jump: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_q == SBL_ST_UPD && !in_band && lp.tc == 3'h0 |=> lp.est == $signed({2'b00, $past(avg_q)}))
        else $error("time constant zero did not jump to average");
    a_avg_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
        wrap |=> lp.avg_vld && lp.avg == $past(acc_sum[ACC_W-1:SAMPLES_LOG2]) ##1 !lp.avg_vld)
        else $error("black average not reported");

endmodule

// >>> design/sbl_black_level_ctrl.sv
// black level cancellation and analog control register bank
`timescale 1ns/1ps
// Operation
// - low mode bit zero: measure only, pass pixels
// - mode 01: add internal offset to pixels
// - mode 11: apply programmed external offset instead
// - three-bit time constant sets loop speed
// - hold integrator within deadband, four or two
// - control zero: clamp and bit-line test enables
// - control zero bits 3:2 select white reference
// - control zero bit 4 enables anti-blooming
// - control zero bit 5 powers down differential clock comparator
// - bits 6,7 power down memory comparator, current source
// - control one bit 0 selects standby
// - control one bits 1-5 individual power downs
// - bit 6 ramp common mode, bit 7 bias
// - converter stepped ramp and differential ramp enables
// - converter view selections for observation output
// - analog test bits 4:3 integration phase delay
// - external offset eleven-bit two's complement register pair
module sbl_black_level_ctrl import sbl_pkg::*; #(
    parameter int PIX_W = 10,
    parameter int SAMPLES_LOG2 = 4,
    parameter int TARGET = 64
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_idx,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [PIX_W-1:0] pix_in,
    input wire logic pix_in_vld,
    input wire logic pix_in_black,
    output logic [PIX_W-1:0] pix_out,
    output logic pix_out_vld,
    output logic [PIX_W-1:0] black_avg,
    output logic black_avg_vld,
    output logic bl_clamp_en,
    output logic bl_test_en,
    output logic [1:0] white_ref_sel,
    output logic anti_bloom_en,
    output logic diff_clk_cmp_pd,
    output logic mem_cmp_pd,
    output logic controlled_current_source_pd,
    output logic standby,
    output logic ramp_gen_pd,
    output logic column_adc_pd,
    output logic array_regulator_powerdown,
    output logic audio_regulator_powerdown,
    output logic top_reference_voltage_amp_pd,
    output logic ramp_cm_fixed,
    output logic cmp_bias_low,
    output logic voltage_doubler_en,
    output logic diff_ramp_en,
    output logic view_cascode,
    output logic ramp_view_test,
    output logic stepped_ramp_en,
    output logic mem_test_en,
    output logic [1:0] top_reference_voltage_sel,
    output logic [1:0] line_integration_phase,
    output logic [1:0] read_integration_phase
);
    // ============================================================
    // register state
    logic [7:0] ofs_hi_q; // external offset, bits 10:8 in 2:0
    logic [7:0] ofs_lo_q; // external offset, bits 7:0
    logic [7:0] setup_q; // black_cancel_setup
    logic [7:0] actl0_q; // analog_control_zero
    logic [7:0] actl1_q; // analog_control_one
    logic [7:0] conv_q; // converter_setup
    logic [7:0] atest_q; // analog_test
    logic [7:0] rdata_q; // read answer
    logic [PIX_W-1:0] pix_q; // corrected pixel
    logic pix_vld_q;
    logic [PIX_W-1:0] avg_out_q; // registered copy of the loop average
    logic avg_vld_out_q;

    // ============================================================
    // pixel path signals
    logic [1:0] mode; // cancellation mode
    logic signed [10:0] ext_ofs; // programmed offset
    logic signed [SUM_W-1:0] int_ofs; // internally derived offset
    logic signed [SUM_W-1:0] ofs_sel; // offset in use
    logic signed [SUM_W-1:0] pix_sum; // pixel plus offset

    sbl_loop_if #(.PIX_W(PIX_W)) lp_if ();

    // ============================================================
    // black level loop
    sbl_black_loop #(
        .PIX_W(PIX_W),
        .SAMPLES_LOG2(SAMPLES_LOG2),
        .TARGET(TARGET)
    ) u_loop (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .lp(lp_if.loop)
    );

    // loop sees raw pixels in every mode so the average is always reported
    assign lp_if.pix = pix_in;
    assign lp_if.pix_vld = pix_in_vld;
    assign lp_if.black = pix_in_black;
    assign lp_if.tc = setup_q[BS_TC_LO +: 3];
    assign lp_if.narrow = setup_q[BS_NARROW];

    // ============================================================
    // register writes; masked bits never store, so they read back zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ofs_hi_q <= RST_BLK_OFS_HI;
            ofs_lo_q <= RST_BLK_OFS_LO;
            setup_q <= RST_BLK_SETUP;
            actl0_q <= RST_ACTL0;
            actl1_q <= RST_ACTL1;
            conv_q <= RST_CONV;
            atest_q <= RST_ATEST;
        end else if (reg_wr) begin
            case (reg_idx)
                IDX_BLK_OFS_HI: ofs_hi_q <= reg_wdata & MSK_BLK_OFS_HI;
                IDX_BLK_OFS_LO: ofs_lo_q <= reg_wdata;
                IDX_BLK_SETUP: setup_q <= reg_wdata & MSK_BLK_SETUP;
                IDX_ACTL0: actl0_q <= reg_wdata;
                IDX_ACTL1: actl1_q <= reg_wdata;
                IDX_CONV: conv_q <= reg_wdata & MSK_CONV;
                IDX_ATEST: atest_q <= reg_wdata & MSK_ATEST;
                default: begin
                    // unmapped index, write dropped
                end
            endcase
        end
    end

    // ============================================================
    // read answer, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_idx)
                IDX_BLK_OFS_HI: rdata_q <= ofs_hi_q;
                IDX_BLK_OFS_LO: rdata_q <= ofs_lo_q;
                IDX_BLK_SETUP: rdata_q <= setup_q;
                IDX_ACTL0: rdata_q <= actl0_q;
                IDX_ACTL1: rdata_q <= actl1_q;
                IDX_CONV: rdata_q <= conv_q;
                IDX_ATEST: rdata_q <= atest_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // ============================================================
    // offset selection
    assign mode = setup_q[BS_MODE_LO +: 2];
    assign ext_ofs = $signed({ofs_hi_q[2:0], ofs_lo_q});
    // the estimate tracks raw black, so the offset pulls black onto the target
    assign int_ofs = SUM_W'(TARGET) - SUM_W'(lp_if.est);

    always_comb begin
        ofs_sel = '0;
        if (mode == MODE_EXTERNAL) begin
            ofs_sel = SUM_W'(ext_ofs);
        end else if (mode == MODE_INTERNAL) begin
            ofs_sel = int_ofs;
        end
    end

    assign pix_sum = $signed({{(SUM_W - PIX_W){1'b0}}, pix_in}) + ofs_sel;

    // ============================================================
    // corrected pixel stream, one cycle latency, clipped to range
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pix_q <= '0;
            pix_vld_q <= 1'b0;
        end else begin
            pix_vld_q <= pix_in_vld;
            if (pix_in_vld) begin
                pix_q <= sbl_clip(pix_sum);
            end
        end
    end

    // average report, registered for a clean output
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            avg_out_q <= '0;
            avg_vld_out_q <= 1'b0;
        end else begin
            avg_vld_out_q <= lp_if.avg_vld;
            avg_out_q <= lp_if.avg;
        end
    end

    // ============================================================
    // outputs, all straight from the registers above
    assign reg_rdata = rdata_q;
    assign pix_out = pix_q;
    assign pix_out_vld = pix_vld_q;
    assign black_avg = avg_out_q;
    assign black_avg_vld = avg_vld_out_q;
    // analog control zero
    assign bl_clamp_en = actl0_q[A0_CLAMP];
    assign bl_test_en = actl0_q[A0_TEST];
    assign white_ref_sel = actl0_q[A0_WREF_LO +: 2];
    assign anti_bloom_en = actl0_q[A0_ANTIBLOOM];
    // only the differential receiver drops; the single-ended clock stays live
    assign diff_clk_cmp_pd = actl0_q[A0_DIFF_CLK_PD];
    assign mem_cmp_pd = actl0_q[A0_MEM_CMP_PD];
    assign controlled_current_source_pd = actl0_q[A0_CCS_PD];
    // analog control one; standby leaves the bandgap running
    assign standby = actl1_q[A1_STANDBY];
    assign ramp_gen_pd = actl1_q[A1_RAMP_PD];
    assign column_adc_pd = actl1_q[A1_COL_ADC_PD];
    assign array_regulator_powerdown = actl1_q[A1_ARRAY_REG_PD];
    assign audio_regulator_powerdown = actl1_q[A1_AUDIO_REG_PD];
    assign top_reference_voltage_amp_pd = actl1_q[A1_TOPREF_PD];
    assign ramp_cm_fixed = actl1_q[A1_RAMP_CM];
    assign cmp_bias_low = actl1_q[A1_CMP_BIAS];
    // converter setup; the doubler is left to software
    assign voltage_doubler_en = conv_q[CV_DOUBLER];
    assign diff_ramp_en = conv_q[CV_DIFF_RAMP];
    assign view_cascode = conv_q[CV_VIEW_CAS];
    assign ramp_view_test = conv_q[CV_VIEW_TEST];
    assign stepped_ramp_en = conv_q[CV_STEPPED];
    // analog test; both integration phases follow one field
    assign mem_test_en = atest_q[AT_MEM_TEST];
    assign top_reference_voltage_sel = atest_q[AT_TOPREF_LO +: 2];
    assign line_integration_phase = atest_q[AT_PHASE_LO +: 2];
    assign read_integration_phase = atest_q[AT_PHASE_LO +: 2];

    // ============================================================
    // checks
    a_bypass_pass: assert property (@(posedge clk_sys) disable iff (!rstn)
        pix_in_vld && !mode[0] |=> pix_out_vld && pix_out == $past(pix_in))
        else $error("pixel altered with cancellation off");
    a_internal_apply: assert property (@(posedge clk_sys) disable iff (!rstn)
        pix_in_vld && mode == MODE_INTERNAL |=>
        pix_out == sbl_clip($signed({3'b000, $past(pix_in)}) + SUM_W'(TARGET) - SUM_W'($past(lp_if.est))))
        else $error("internal offset not applied");
    a_external_apply: assert property (@(posedge clk_sys) disable iff (!rstn)
        pix_in_vld && mode == MODE_EXTERNAL |=>
        pix_out == sbl_clip($signed({3'b000, $past(pix_in)}) + SUM_W'($past(ext_ofs))))
        else $error("external offset not applied");
    a_clamp_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_wr && reg_idx == IDX_ACTL0 |=> bl_clamp_en == $past(reg_wdata[0]) && bl_test_en == $past(reg_wdata[1]))
        else $error("clamp or test enable not updated");
    a_white_ref: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_wr && reg_idx == IDX_ACTL0 |=> white_ref_sel == $past(reg_wdata[3:2]))
        else $error("white reference not updated");
    a_standby_set: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_wr && reg_idx == IDX_ACTL1 && reg_wdata[0] |=> standby ##1 (standby || $past(reg_wr)))
        else $error("standby not entered");
    a_phase_both: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_wr && reg_idx == IDX_ATEST |=>
        line_integration_phase == $past(reg_wdata[4:3]) && read_integration_phase == line_integration_phase)
        else $error("integration phasing wrong");
    a_unused_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_rd && reg_idx == IDX_BLK_SETUP |=> reg_rdata[7:6] == 2'b00)
        else $error("unused setup bits read non zero");
    a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_rd && (reg_idx == 8'h73 || reg_idx == 8'h74) |=> reg_rdata == 8'h00)
        else $error("unmapped index read non zero");

endmodule

// >>> verif/sbl_bus_master.sv
// serial bus master model driving the register strobes of the bank
`timescale 1ns/1ps
module sbl_bus_master(
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_idx,
    output logic [7:0] reg_wdata
);
    // ==========================================
    // idle bus: no strobe before reset is released
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_idx = 8'h00;
        reg_wdata = 8'h00;
    end

    // ==========================================
    // one byte write with an 8-bit index, strobe held a single cycle
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_idx <= i;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // one byte read; data is registered, so it is taken just after the taking edge
    task automatic rd(input logic [7:0] i, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_idx <= i;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

// >>> verif/sbl_black_level_ctrl_tb.sv
// self-checking bench of the black level and analog control bank
`timescale 1ns/1ps
module sbl_black_level_ctrl_tb import sbl_pkg::*;;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [9:0] pix_in = 10'h000;
    logic pix_in_vld = 1'b0;
    logic pix_in_black = 1'b0;
    logic [7:0] reg_rdata, reg_idx, reg_wdata, rv;
    logic reg_wr, reg_rd, pix_out_vld, black_avg_vld;
    logic [9:0] pix_out, black_avg, v;
    logic bl_clamp_en, bl_test_en, anti_bloom_en, diff_clk_cmp_pd, mem_cmp_pd, controlled_current_source_pd;
    logic standby, ramp_gen_pd, column_adc_pd, array_regulator_powerdown, audio_regulator_powerdown;
    logic top_reference_voltage_amp_pd, ramp_cm_fixed, cmp_bias_low, voltage_doubler_en, diff_ramp_en;
    logic view_cascode, ramp_view_test, stepped_ramp_en, mem_test_en;
    logic [1:0] white_ref_sel, top_reference_voltage_sel, line_integration_phase, read_integration_phase;
    logic [7:0] ev [0:255]; // expected register contents
    int n_fail = 0;
    int n_compared = 0;
    int seed = 6178;

    always #25 clk_sys = ~clk_sys;
    sbl_black_level_ctrl dut_u (.*);
    sbl_bus_master bm_u (.*);

    // ==========================================
    // checking helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // bits that store; everything else reads zero
    function automatic logic [7:0] msk(input logic [7:0] i);
        case (i)
            IDX_BLK_OFS_HI: return MSK_BLK_OFS_HI;
            IDX_BLK_SETUP: return MSK_BLK_SETUP;
            IDX_CONV: return MSK_CONV;
            IDX_ATEST: return MSK_ATEST;
            IDX_BLK_OFS_LO, IDX_ACTL0, IDX_ACTL1: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction
    // expected page right after any reset; unmapped bytes read zero
    task automatic ev_rst();
        for (int i = 0; i < 256; i++) ev[i] = 8'h00;
        ev[IDX_BLK_OFS_HI] = RST_BLK_OFS_HI;
        ev[IDX_BLK_OFS_LO] = RST_BLK_OFS_LO;
        ev[IDX_BLK_SETUP] = RST_BLK_SETUP;
        ev[IDX_ACTL0] = RST_ACTL0;
        ev[IDX_ACTL1] = RST_ACTL1;
        ev[IDX_CONV] = RST_CONV;
        ev[IDX_ATEST] = RST_ATEST;
    endtask
    task automatic put(input logic [7:0] i, input logic [7:0] d);
        bm_u.wr(i, d);
        ev[i] = d & msk(i);
    endtask
    // read back the page, unmapped bytes included, then the analog level pins
    task automatic sweep();
        for (int i = 8'h70; i <= 8'h78; i++) begin
            bm_u.rd(i[7:0], rv);
            chk("reg", {i[7:0], rv}, {i[7:0], ev[i]});
        end
        chk("analog", {controlled_current_source_pd, mem_cmp_pd, diff_clk_cmp_pd, anti_bloom_en, white_ref_sel,
            bl_test_en, bl_clamp_en, cmp_bias_low, ramp_cm_fixed, top_reference_voltage_amp_pd,
            audio_regulator_powerdown, array_regulator_powerdown, column_adc_pd, ramp_gen_pd, standby,
            stepped_ramp_en, ramp_view_test, view_cascode, diff_ramp_en, voltage_doubler_en,
            line_integration_phase, read_integration_phase, top_reference_voltage_sel, mem_test_en},
            {ev[8'h75], ev[8'h76], ev[8'h77][6:2], ev[8'h78][4:3], ev[8'h78][4:3], ev[8'h78][2:0]});
    endtask
    // one pixel, output checked one cycle after it is taken
    task automatic px(input logic [9:0] p, input logic b, input logic [9:0] exp);
        @(posedge clk_sys);
        pix_in <= p;
        pix_in_vld <= 1'b1;
        pix_in_black <= b;
        @(posedge clk_sys);
        pix_in_vld <= 1'b0;
        #1;
        chk("pix_out", {pix_out_vld, pix_out}, {1'b1, exp});
    endtask
    // one block of sixteen black pixels alternating v and v+1, so the floor average is v
    task automatic blk(input logic [9:0] a);
        for (int k = 0; k < 16; k++) begin
            px(a + 10'(k % 2), 1'b1, a + 10'(k % 2));
        end
        for (int t = 0; t < 4 && black_avg_vld !== 1'b1; t++) begin
            @(posedge clk_sys);
            #1;
        end
        chk("black_avg", {black_avg_vld, black_avg}, {1'b1, a});
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        ev_rst();
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        sweep();
        px(10'h200, 1'b0, 10'h200);
        // tc zero so one step moves the estimate by the whole error
        put(IDX_BLK_SETUP, 8'h01);
        blk(10'd68);
        px(10'd500, 1'b0, 10'd500);
        put(IDX_BLK_SETUP, 8'h21);
        blk(10'd67);
        px(10'd500, 1'b0, 10'd497);
        // external offset, default -64, then clipping at both ends
        put(IDX_BLK_SETUP, 8'h03);
        put(IDX_BLK_OFS_HI, 8'h07);
        put(IDX_BLK_OFS_LO, 8'hC0);
        px(10'd100, 1'b0, 10'd36);
        px(10'd20, 1'b0, 10'd0);
        put(IDX_BLK_OFS_HI, 8'h03);
        put(IDX_BLK_OFS_LO, 8'hFF);
        px(10'd1000, 1'b0, 10'h3FF);
        repeat (8) begin
            for (int i = 8'h70; i <= 8'h78; i++) put(i[7:0], 8'($random(seed)));
            sweep();
        end
        // reset in mid-run puts the analog page back to its reset contents
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        ev_rst();
        sweep();
        // doubler on for a low supply; mode 10 must still pass pixels untouched
        put(IDX_CONV, RST_CONV | 8'h04);
        put(IDX_BLK_SETUP, 8'h02);
        px(10'd100, 1'b0, 10'd100);
        sweep();
        put(IDX_BLK_SETUP, 8'h00);
        v = 10'($unsigned($random(seed)) % 1000);
        blk(v);
        final_report();
    end

    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        #2000000;
        n_fail++;
        final_report();
    end
endmodule
